// ### cfq_pkg.sv
// Purpose: Constants for the flash query and secured-region host controller
// Assumes: 16-bit parallel flash bus, clocked at 250 MHz
// Notes: Query table bounds and command codes used by the controller
package cfq_pkg;
	localparam int CLK_MHZ = 250; // System clock rate
	localparam int ADDR_W = 20; // Word address width
	localparam int DATA_W = 16; // Data bus width
	// Bus cycle times, in ns and in system clocks
	localparam int T_CYCLE_NS = 70; // Least access or write pulse time
	localparam int CYC_BUS = (T_CYCLE_NS * CLK_MHZ + 999) / 1000; // Rounded up
	localparam logic [4:0] CYC_BUS_W = 5'(CYC_BUS); // Write strobe threshold for the phase timer
	localparam logic [5:0] CYC_PHASE = 6'(2 * CYC_BUS); // Whole phase, strobe low then high
	// Command codes and addresses
	localparam logic [7:0] CMD_QUERY = 8'h98; // Enter query
	localparam logic [7:0] CMD_RESET = 8'hF0; // Reset to array read
	localparam logic [7:0] CMD_UNLK1 = 8'hAA; // First unlock data
	localparam logic [7:0] CMD_UNLK2 = 8'h55; // Second unlock data
	localparam logic [7:0] CMD_SEC_ENTER = 8'h88; // Enter secured region
	localparam logic [7:0] CMD_SEC_EXIT = 8'h90; // Exit secured region, first byte
	localparam logic [7:0] CMD_SEC_EXIT2 = 8'h00; // Exit secured region, last byte
	localparam logic [7:0] CMD_PROT = 8'h60; // Protect algorithm cycle
	localparam logic [ADDR_W-1:0] ADR_QUERY_W = 20'h00055; // Query address, word mode
	localparam logic [ADDR_W-1:0] ADR_QUERY_B = 20'h000AA; // Query address, byte mode
	localparam logic [ADDR_W-1:0] ADR_UNLK1 = 20'h00555; // First unlock address
	localparam logic [ADDR_W-1:0] ADR_UNLK2 = 20'h002AA; // Second unlock address
	localparam logic [ADDR_W-1:0] ADR_SEC_LOCK = 20'h00002; // Lock cycle address
	localparam logic [ADDR_W-1:0] ADR_ESN_LO = 20'h0F8000; // Serial number start
	localparam logic [ADDR_W-1:0] ADR_ESN_HI = 20'h0F8007; // Serial number end
	localparam logic [6:0] QRY_LO = 7'h10; // First query word address
	localparam logic [6:0] QRY_HI = 7'h3C; // Last query word address
	localparam logic [6:0] QRY_UPPER_MASK = 7'h00; // A7 and up must be zero
	typedef enum logic [2:0] {
		CFQ_OP_QUERY, CFQ_OP_READ, CFQ_OP_EXIT, CFQ_OP_SEC_ENTER, CFQ_OP_SEC_EXIT, CFQ_OP_LOCK, CFQ_OP_AUTO
	} cfq_op_type;
endpackage : cfq_pkg

// ### cfq_rom.sv
// Purpose: Expected query table for checking what the flash returns
// Assumes: Word addresses 10h to 3Ch
// Notes: Data comes out of a register one cycle after the address
`timescale 1ns/1ns
module cfq_rom
	import cfq_pkg::*;
(
	input wire logic sys_clk, // System clock
	input wire logic nrst, // Async reset, active low
	input wire logic [6:0] addr, // Query word address
	output logic [15:0] data // Expected word, registered
);
	logic [15:0] val; // Table lookup result

	// Table of expected query words
	always_comb begin
		unique case (addr)
			7'h10: val = 16'h0051;
			7'h11: val = 16'h0052;
			7'h12: val = 16'h0059;
			7'h13: val = 16'h0002;
			7'h15: val = 16'h0040;
			7'h1B: val = 16'h0027;
			7'h1C: val = 16'h0036;
			7'h1F: val = 16'h0007;
			7'h21: val = 16'h000A;
			7'h23: val = 16'h0001;
			7'h25: val = 16'h0004;
			7'h27: val = 16'h0015;
			7'h28: val = 16'h0002;
			7'h2C: val = 16'h0004;
			7'h2F: val = 16'h0040;
			7'h31: val = 16'h0001;
			7'h33: val = 16'h0020;
			7'h37: val = 16'h0080;
			7'h39: val = 16'h001E;
			7'h3C: val = 16'h0001;
			default: val = 16'h0000; // and all other zero words
		endcase
	end

	// Register the read data
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			data <= 16'h0000;
		end else begin
			data <= val;
		end
	end
endmodule : cfq_rom

// ### cfq_host.sv
// Purpose: Host controller driving flash query and secured-region locking
// Assumes: Flash pins driven straight from flops, one access at a time
// Notes: Each bus phase lasts a fixed number of system clocks
// Function
// - Query command 98h at 55h or AAh
// - Host zeroes A7 upward in word query
// - Only reset command leaves query mode
// - Unlocked secured region accepts all programming; the host has no program operation and issues no program cycles
// - Lock: enter region then protect algorithm
// - Region exit before array access: the host issues none, CFQ_OP_READ goes out with in_secure still set
`timescale 1ns/1ns
module cfq_host
	import cfq_pkg::*;
(
	input wire logic sys_clk, // System clock
	input wire logic nrst, // Async reset, active low
	input wire logic cmd_valid, // Request strobe
	output logic cmd_ready, // Idle, request taken
	input wire logic [2:0] cmd_op, // Operation code
	input wire logic [ADDR_W-1:0] cmd_addr, // Read address; a byte address in byte mode
	input wire logic byte_mode, // Flash in byte mode
	output logic rsp_valid, // One-cycle answer pulse
	output logic [15:0] rsp_data, // Read data
	output logic rsp_match, // Query word equals expected
	output logic in_query, // Query mode is active
	output logic in_secure, // Secured region entered
	output logic [ADDR_W-1:0] fl_addr, // Flash address
	output logic [15:0] fl_dq_o, // Flash data out
	output logic fl_dq_oe, // Flash data drive enable
	input wire logic [15:0] fl_dq_i, // Flash data in
	output logic fl_ce_n, // Chip enable, low
	output logic fl_oe_n, // Output enable, low
	output logic fl_we_n // Write enable, low
);
	typedef enum logic [1:0] {ST_IDLE, ST_WR, ST_RD, ST_DONE} cfq_st_type;
	cfq_st_type st_r, st_nxt; // Sequencer state
	logic [5:0] cnt_r; // Phase timer, wide enough for a whole phase
	logic [2:0] idx_r; // Cycle index within sequence
	logic [2:0] op_r; // Latched operation
	logic [ADDR_W-1:0] ra_r; // Latched read address
	logic byte_r; // Latched bus mode
	logic qry_r, sec_r; // Mode trackers
	logic [15:0] exp_data; // Expected query word
	logic [6:0] rom_a; // Query table index
	logic [2:0] nwr; // Write cycles for this op
	logic [ADDR_W-1:0] wa; // Write address of current cycle
	logic [7:0] wd; // Write data of current cycle
	logic timer_done; // Phase elapsed
	logic qry_word; // Read lies in the query table

	// Commands, one bus cycle per write index
	function automatic logic [27:0] seq_cycle(input logic [2:0] op, input logic [2:0] i, input logic bm);
		logic [19:0] a;
		logic [7:0] d;
		a = (i == 3'd1) ? ADR_UNLK2 : ADR_UNLK1;
		d = (i == 3'd0) ? CMD_UNLK1 : (i == 3'd1) ? CMD_UNLK2 : CMD_SEC_ENTER;
		unique case (op)
			CFQ_OP_QUERY: begin
				a = bm ? ADR_QUERY_B : ADR_QUERY_W;
				d = CMD_QUERY;
			end
			CFQ_OP_AUTO: d = (i == 3'd2) ? 8'h90 : d;
			CFQ_OP_EXIT: begin
				a = '0;
				d = CMD_RESET;
			end
			CFQ_OP_SEC_EXIT: begin
				d = (i == 3'd2) ? CMD_SEC_EXIT : (i == 3'd3) ? CMD_SEC_EXIT2 : d;
				a = (i == 3'd3) ? '0 : a;
			end
			CFQ_OP_LOCK: begin
				a = (i >= 3'd3) ? ADR_SEC_LOCK : a;
				d = (i >= 3'd3) ? CMD_PROT : d;
			end
			default: begin
			end
		endcase
		if (bm && op != CFQ_OP_QUERY && op != CFQ_OP_EXIT) a = {a[18:0], 1'b0};
		return {a, d};
	endfunction : seq_cycle

	// Write cycles in each operation's sequence
	function automatic logic [2:0] nwr_l(input logic [2:0] o);
		return (o == CFQ_OP_QUERY || o == CFQ_OP_EXIT) ? 3'd1 :
			(o == CFQ_OP_SEC_EXIT || o == CFQ_OP_LOCK) ? 3'd4 : 3'd3;
	endfunction : nwr_l

	// Length of the latched operation, so the sequencer runs every write
	assign nwr = nwr_l(op_r);
	assign {wa, wd} = seq_cycle(op_r, idx_r, byte_r);
	assign timer_done = (cnt_r == 6'd0);
	assign cmd_ready = (st_r == ST_IDLE);
	assign in_query = qry_r;
	assign in_secure = sec_r;
	// Byte mode reads sit at twice the word address
	assign rom_a = byte_r ? ra_r[7:1] : ra_r[6:0];
	assign qry_word = qry_r && (rom_a >= QRY_LO) && (rom_a <= QRY_HI);

	cfq_rom u_rom (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.addr(rom_a),
		.data(exp_data)
	);

	// Next state of the access sequencer
	always_comb begin
		st_nxt = st_r;
		unique case (st_r)
			ST_IDLE: if (cmd_valid) st_nxt = (cmd_op == CFQ_OP_READ) ? ST_RD : ST_WR;
			ST_WR: if (timer_done && (idx_r + 3'd1 == nwr)) st_nxt = ST_DONE;
			ST_RD: if (timer_done) st_nxt = ST_DONE;
			ST_DONE: st_nxt = ST_IDLE;
		endcase
	end

	// State and timer
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			st_r <= ST_IDLE;
			cnt_r <= 6'd0;
		end else begin
			st_r <= st_nxt;
			cnt_r <= (st_r == ST_IDLE || timer_done) ? CYC_PHASE : cnt_r - 6'd1;
		end
	end

	// Latch the request; idx counts up through the writes
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			op_r <= CFQ_OP_READ;
			ra_r <= '0;
			byte_r <= 1'b0;
			idx_r <= 3'd0;
		end else if (cmd_ready && cmd_valid) begin
			op_r <= cmd_op;
			// Word query reads keep A7 and up at zero
			ra_r <= (qry_r && !byte_mode) ? {13'h0, cmd_addr[6:0]} : cmd_addr;
			byte_r <= byte_mode;
			idx_r <= 3'd0;
		end else if (st_r == ST_WR && timer_done) begin
			idx_r <= (idx_r + 3'd1 == nwr) ? 3'd0 : idx_r + 3'd1;
		end
	end

	// Mode tracking: query and secured region
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			qry_r <= 1'b0;
			sec_r <= 1'b0;
		end else if (st_r == ST_DONE) begin
			if (op_r == CFQ_OP_QUERY) qry_r <= 1'b1;
			if (op_r == CFQ_OP_EXIT) qry_r <= 1'b0;
			if (op_r == CFQ_OP_SEC_ENTER || op_r == CFQ_OP_LOCK) sec_r <= 1'b1;
			if (op_r == CFQ_OP_SEC_EXIT) sec_r <= 1'b0;
		end
	end

	// Flash pin drive: first half of a write phase asserts the write strobe
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			fl_addr <= '0;
			fl_dq_o <= 16'h0000;
			fl_dq_oe <= 1'b0;
			fl_ce_n <= 1'b1;
			fl_oe_n <= 1'b1;
			fl_we_n <= 1'b1;
		end else begin
			fl_ce_n <= !(st_nxt == ST_WR || st_nxt == ST_RD);
			fl_addr <= (st_r == ST_RD || st_nxt == ST_RD) ? ra_r : wa;
			fl_dq_o <= {8'h00, wd};
			fl_dq_oe <= (st_r == ST_WR);
			fl_we_n <= !(st_r == ST_WR && cnt_r > {1'b0, CYC_BUS_W});
			fl_oe_n <= !(st_r == ST_RD);
		end
	end

	// Capture read data and compare with the expected table
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rsp_valid <= 1'b0;
			rsp_data <= 16'h0000;
			rsp_match <= 1'b0;
		end else begin
			rsp_valid <= (st_r == ST_DONE);
			if (st_r == ST_RD && timer_done) begin
				rsp_data <= byte_r ? {8'h00, fl_dq_i[7:0]} : fl_dq_i;
				// Serial words and locked region are read-only; only reads reach them
				rsp_match <= qry_word && ((byte_r ? {8'h00, fl_dq_i[7:0]} : fl_dq_i) == exp_data);
			end
		end
	end

	a_pins_idle: assert property (@(posedge sys_clk) disable iff (!nrst)
		(st_r == ST_IDLE) |=> fl_we_n && fl_oe_n) else $error("strobe active while idle");
	a_query_enter: assert property (@(posedge sys_clk) disable iff (!nrst)
		(st_r == ST_DONE && op_r == CFQ_OP_QUERY) |=> in_query) else $error("query mode not entered");
	a_query_exit: assert property (@(posedge sys_clk) disable iff (!nrst)
		(st_r == ST_DONE && op_r == CFQ_OP_EXIT) |=> !in_query) else $error("query mode not left");
	a_query_stay: assert property (@(posedge sys_clk) disable iff (!nrst)
		(in_query && st_r == ST_DONE && op_r == CFQ_OP_READ) |=> in_query) else $error("read left query mode");
	a_word_high: assert property (@(posedge sys_clk) disable iff (!nrst)
		(st_r == ST_RD && in_query && !byte_r) |-> ra_r[19:7] == 13'h0) else $error("upper bits set");
	a_sec_exit: assert property (@(posedge sys_clk) disable iff (!nrst)
		(st_r == ST_DONE && op_r == CFQ_OP_SEC_EXIT) |=> !in_secure) else $error("region not left");
	a_rsp_pulse: assert property (@(posedge sys_clk) disable iff (!nrst)
		rsp_valid |=> !rsp_valid) else $error("answer longer than one cycle");
	a_data_off: assert property (@(posedge sys_clk) disable iff (!nrst)
		!fl_we_n |-> fl_dq_oe) else $error("write without data drive");
endmodule : cfq_host

// ### cfq_tab_pkg.sv
// Purpose: Query table image shared by the flash model and the bench
// Assumes: Word addresses 10h to 3Ch
// Notes: Values held as low bytes; the upper byte of each word is zero
package cfq_tab_pkg;
	localparam logic [0:44][7:0] QTAB = {
		8'h51, 8'h52, 8'h59, 8'h02, 8'h00, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h27, 8'h36, 8'h00, 8'h00, 8'h07, 8'h00, 8'h0A, 8'h00, 8'h01, 8'h00, 8'h04, 8'h00,
		8'h15, 8'h02, 8'h00, 8'h00, 8'h00, 8'h04,
		8'h00, 8'h00, 8'h40, 8'h00, 8'h01, 8'h00, 8'h20, 8'h00,
		8'h00, 8'h00, 8'h80, 8'h00, 8'h1E, 8'h00, 8'h00, 8'h01}; // Query words 10h up
	// Word at a query address, zero outside the table
	function automatic logic [15:0] qtab_word(input logic [6:0] a);
		return (a >= 7'h10 && a <= 7'h3C) ? {8'h00, QTAB[a - 7'h10]} : 16'h0000;
	endfunction : qtab_word
endpackage : cfq_tab_pkg

// ### cfq_flash_model.sv
// Purpose: Behavioural parallel flash for query and secured-region cycles
// Assumes: No clock; commands latched at the rising write strobe
// Notes: A released bus shows the inverse of the last value read
`timescale 1ns/1ns
module cfq_flash_model
	import cfq_tab_pkg::*;
(
	input wire logic [19:0] fl_addr, // Flash address
	input wire logic [15:0] fl_dq_o, // Data from host
	input wire logic fl_dq_oe, // Host drives data
	output logic [15:0] fl_dq_i, // Data to host
	input wire logic fl_ce_n, // Chip enable, low
	input wire logic fl_oe_n, // Output enable, low
	input wire logic fl_we_n, // Write enable, low
	input wire logic byte_mode, // Bus in byte mode
	output logic locked, // Secured region locked
	output logic addr_err // Upper query address bits seen set
);
	logic qry_r = 1'b0; // Query mode, off at power-up
	logic auto_r = 1'b0; // Autoselect mode
	logic sec_r = 1'b0; // Secured region entered
	logic [7:0] prev_r = 8'h00; // Previous command byte
	logic [15:0] last_r = 16'h0000; // Last value read
	logic [15:0] val; // Word chosen by mode
	wire [19:0] wa = byte_mode ? {1'b0, fl_addr[19:1]} : fl_addr;
	wire [7:0] cd = fl_dq_o[7:0]; // Command byte
	initial locked = 1'b0;
	initial addr_err = 1'b0;
	// Command decode
	always @(posedge fl_we_n) begin
		if (!fl_ce_n && fl_dq_oe) begin
			if (cd == 8'hF0) begin
				qry_r = 1'b0;
				auto_r = 1'b0;
			end
			if (cd == 8'h98 && fl_addr == (byte_mode ? 20'h000AA : 20'h00055)) qry_r = 1'b1;
			if (cd == 8'h88) sec_r = 1'b1;
			if (cd == 8'h90 && !sec_r) auto_r = 1'b1;
			if (cd == 8'h00 && prev_r == 8'h90) sec_r = 1'b0;
			if (cd == 8'h60 && sec_r) locked = 1'b1;
			prev_r = cd;
		end
	end
	// Word mode query reads must keep A7 and up at zero
	always @(negedge fl_oe_n) if (qry_r && !byte_mode && fl_addr[19:7] != 13'h0000) addr_err = 1'b1;
	// Remember the word driven while selected, so a released bus shows its inverse
	always @(val, fl_ce_n, fl_oe_n) if (!fl_ce_n && !fl_oe_n) last_r = val;
	assign val = qry_r ? qtab_word(wa[6:0]) : (sec_r && wa[19:3] == 17'h1F000) ? {8'hE5, 5'h00, wa[2:0]} :
		wa[15:0] ^ 16'h3C3C;
	assign fl_dq_i = (!fl_ce_n && !fl_oe_n) ? (byte_mode ? {~last_r[15:8], val[7:0]} : val) : ~last_r;
endmodule : cfq_flash_model

// ### tb_top.sv
// Purpose: Self-checking bench for the query and secured-region host
// Assumes: Flash model on the far side
// Notes: Random addresses from seed 54
`timescale 1ns/1ns
module tb_top import cfq_pkg::*, cfq_tab_pkg::*;;
	logic sys_clk = 1'b0; // Clock
	logic nrst = 1'b0; // Reset
	logic cmd_valid = 1'b0; // Request
	logic [2:0] cmd_op = 3'h0; // Operation
	logic [19:0] cmd_addr = 20'h00000; // Address
	logic byte_mode = 1'b0; // Bus mode
	logic cmd_ready, rsp_valid, rsp_match, in_query, in_secure, fl_dq_oe, fl_ce_n, fl_oe_n, fl_we_n, locked, addr_err;
	logic [15:0] rsp_data, fl_dq_o, fl_dq_i; // Data
	logic [19:0] fl_addr; // Flash address
	int bad_count = 0; // Mismatches
	int checked = 0; // Comparisons
	int a; // Loop index
	cfq_host u_cfq_host (.sys_clk, .nrst, .cmd_valid, .cmd_ready, .cmd_op, .cmd_addr, .byte_mode, .rsp_valid,
		.rsp_data, .rsp_match, .in_query, .in_secure, .fl_addr, .fl_dq_o, .fl_dq_oe, .fl_dq_i, .fl_ce_n,
		.fl_oe_n, .fl_we_n);
	cfq_flash_model u_cfq_flash_model (.fl_addr, .fl_dq_o, .fl_dq_oe, .fl_dq_i, .fl_ce_n, .fl_oe_n, .fl_we_n,
		.byte_mode, .locked, .addr_err);
	// Clock, 4 ns period
	initial forever #2 sys_clk = ~sys_clk;
	// Verdict and end of run
	task automatic conclude;
		$display("Counts: %0d checked, %0d bad", checked, bad_count);
		if (bad_count == 0 && checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : conclude
	// Compare one value
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		checked++;
		if (g !== e) begin
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
			bad_count++;
		end
	endtask : chk
	// One request, held until taken, then wait for the answer
	task automatic op(input logic [2:0] o, input logic [19:0] ad);
		int n;
		@(posedge sys_clk);
		cmd_valid <= 1'b1;
		cmd_op <= o;
		cmd_addr <= ad;
		n = 0;
		do begin
			@(negedge sys_clk);
			n++;
		end while (cmd_ready !== 1'b1 && n < 4000);
		@(posedge sys_clk);
		cmd_valid <= 1'b0;
		while (rsp_valid !== 1'b1 && n < 4000) begin
			@(negedge sys_clk);
			n++;
		end
		if (n >= 4000) begin
			$display("CHECK FAILED rsp_valid of op %0d expected 1 seen 0", o);
			bad_count++;
			conclude();
		end
	endtask : op
	// Main sequence
	initial begin
		void'($urandom(54));
		repeat (16) @(posedge sys_clk);
		nrst <= 1'b1;
		op(CFQ_OP_QUERY, 20'h00000);
		chk("in_query", 16'h0001, 16'(in_query));
		for (a = 16; a <= 60; a++) begin
			op(CFQ_OP_READ, {13'($urandom), 7'(a)});
			chk("qdata", qtab_word(7'(a)), rsp_data);
			chk("qmatch", 16'h0001, 16'(rsp_match));
		end
		chk("addr_err", 16'h0000, 16'(addr_err));
		$display("Test query table done");
		op(CFQ_OP_EXIT, 20'($urandom));
		chk("in_query", 16'h0000, 16'(in_query));
		a = $urandom_range(60, 16);
		op(CFQ_OP_READ, 20'(a));
		chk("array", 16'(a) ^ 16'h3C3C, rsp_data);
		$display("Test reset done");
		op(CFQ_OP_AUTO, 20'h00000);
		op(CFQ_OP_QUERY, 20'h00000);
		chk("in_query", 16'h0001, 16'(in_query));
		op(CFQ_OP_READ, 20'h00012);
		chk("qdata", 16'h0059, rsp_data);
		op(CFQ_OP_EXIT, 20'h00000);
		$display("Test autoselect done");
		@(posedge sys_clk);
		byte_mode <= 1'b1;
		op(CFQ_OP_QUERY, 20'h00000);
		chk("in_query", 16'h0001, 16'(in_query));
		repeat (6) begin
			a = $urandom_range(60, 16);
			op(CFQ_OP_READ, 20'(2 * a));
			chk("bdata", qtab_word(7'(a)), {8'h00, rsp_data[7:0]});
		end
		op(CFQ_OP_EXIT, 20'h00000);
		@(posedge sys_clk);
		byte_mode <= 1'b0;
		$display("Test byte mode done");
		op(CFQ_OP_SEC_ENTER, 20'h00000);
		chk("in_secure", 16'h0001, 16'(in_secure));
		for (a = 0; a < 8; a++) begin
			op(CFQ_OP_READ, 20'h0F8000 + 20'(a));
			chk("esn", {8'hE5, 5'h00, 3'(a)}, rsp_data);
		end
		op(CFQ_OP_LOCK, 20'h00000);
		chk("locked", 16'h0001, 16'(locked));
		op(CFQ_OP_SEC_EXIT, 20'h00000);
		chk("in_secure", 16'h0000, 16'(in_secure));
		op(CFQ_OP_READ, 20'h0F8000);
		chk("array", 16'h8000 ^ 16'h3C3C, rsp_data);
		$display("Test secured region done");
		conclude();
	end
endmodule : tb_top
